// file: hdl/ssr_instrument.sv
// Instrument end: condition report byte, enable mask and service request.
//
// Functional notes
// - Keep one status byte, six report bits.
// - Enabled set report bit pulls request low.
// - Serial poll clears the latched report bits.
// - Mask bit one enables its report.
// - Mask bit six gates every request.
// - Poll answered even with request gated.
// - Live bits follow instrument state directly.
// - Limit report latches until serial poll.
// - Bit zero: sample reading ready.
// - Bit one: control reading ready.
// - Bit two: reading enters limit band.
// - Bit three: sample channel changed.
// - Bit five: overload on displayed channel.
// - Upper digit: 2 overload, 4 master.
// - Lower digit: 1 sample, 2 control, 4 limit.
// - Missing limit value defaults to zero.
// - Power-up restores saved settings per switch.
// - Query returns mask, comma, band, terminators.
// - Limit report meaningful only in kelvin.
`timescale 1ns/1ps
module ssr_instrument (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Link to the bus controller
  ssr_link_if.instrument   link,
  // Live instrument conditions
  input  wire logic        sampleReady,
  input  wire logic        controlReady,
  input  wire logic        inLimitBand,
  input  wire logic        channelChange,
  input  wire logic        overload,
  input  wire logic        eventSummary,
  // Power-up save settings
  input  wire logic        restoreSwitch,
  input  wire logic        powerUpLoad,
  input  wire logic [7:0]  savedMask,
  input  wire logic [15:0] savedLimit,
  // Current settings for the save store
  output logic [7:0]       maskOut,
  output logic [15:0]      limitOut
);

  // Settings, also mirrored to the save store.
  logic [7:0]  reportEnableMask_reg;
  logic [15:0] controlLimitBand_reg;
  // Latched reports and the assembled report byte.
  logic        limitLatch_reg;
  logic        channelLatch_reg;
  logic [7:0]  conditionReport;
  // Request and serial poll answer.
  logic        srqPull_reg;
  logic        pollAck_reg;
  logic [7:0]  pollByte_reg;
  // Mask query sender.
  logic        queryValid_reg;
  logic [7:0]  queryChar_reg;
  logic [3:0]  queryIndex_reg;
  ssr_pkg::ssr_query_type queryState_reg;

  // Turns a nibble into one printable hex character.
  // Band digits are BCD, so only the decimal half is ever used for them.
  function automatic logic [7:0] hexChar(input logic [3:0] nib);
    hexChar = (nib < 4'ha) ? ssr_pkg::CHAR_ZERO + {4'h0, nib}
                           : ssr_pkg::CHAR_A + {4'h0, nib - 4'ha};
  endfunction : hexChar

  ////////////////////////////////////////////////////////////////////////////
  // Mask and limit band: power-up load, then the set command.
  // The load wins over a set command in the same cycle; the two never meet in
  // normal use, since the load comes once, right after power-on.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reportEnableMask_reg <= ssr_pkg::MASK_DEFAULT;
      controlLimitBand_reg <= ssr_pkg::LIMIT_DEFAULT;
    end else if (powerUpLoad) begin
      reportEnableMask_reg <= restoreSwitch ? savedMask : ssr_pkg::MASK_DEFAULT;
      controlLimitBand_reg <= restoreSwitch ? savedLimit : ssr_pkg::LIMIT_DEFAULT;
    end else if (link.maskSet) begin
      reportEnableMask_reg <= link.maskValue;
      // A band is only meaningful with the limit report enabled.
      // Without the given flag the band falls back to zero, as for a missing value.
      controlLimitBand_reg <= link.limitGiven ? link.limitValue : ssr_pkg::LIMIT_DEFAULT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched reports; a new event in the poll cycle wins over the clear.
  // Latching keeps a short event visible until the controller has polled; a
  // level that is still present simply sets the bit again after the clear.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      limitLatch_reg   <= 1'b0;
      channelLatch_reg <= 1'b0;
    end else begin
      limitLatch_reg   <= inLimitBand | (limitLatch_reg & ~link.pollReq);
      channelLatch_reg <= channelChange | (channelLatch_reg & ~link.pollReq);
    end
  end

  // Report byte: live bits track state; bit 4 carries the event summary.
  // Bits 6 and 7 stay zero here: bit 6 of the poll byte is the request flag.
  // Kept combinational so that a poll always sees the current levels.
  always_comb begin
    conditionReport                       = ssr_pkg::REPORT_RESET;
    conditionReport[ssr_pkg::SAMPLE_BIT]   = sampleReady;
    conditionReport[ssr_pkg::CONTROL_BIT]  = controlReady;
    conditionReport[ssr_pkg::LIMIT_BIT]    = limitLatch_reg;
    conditionReport[ssr_pkg::CHANNEL_BIT]  = channelLatch_reg;
    conditionReport[ssr_pkg::SUMMARY_BIT]  = eventSummary;
    conditionReport[ssr_pkg::OVERLOAD_BIT] = overload;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Service request: master gate and enabled report bits 0 to 5.
  // The request is registered so the line never glitches while the mask and
  // the reports settle; the cost is one cycle of extra latency.
  // It falls again by itself once every enabled bit is low; a poll clears only the latched limit and channel bits.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      srqPull_reg <= 1'b0;
    end else begin
      srqPull_reg <= reportEnableMask_reg[ssr_pkg::MASTER_BIT]
                   & (|(conditionReport[5:0] & reportEnableMask_reg[5:0]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial poll answer: byte taken before the clear, answered regardless of gate.
  // Capturing the pre-clear report means a poll never loses an event that
  // was latched up to that very edge.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pollAck_reg  <= 1'b0;
      pollByte_reg <= ssr_pkg::REPORT_RESET;
    end else begin
      pollAck_reg <= link.pollReq;
      if (link.pollReq) begin
        pollByte_reg <= {1'b0, srqPull_reg, conditionReport[5:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask query: two hex mask characters, comma, four band digits, CR LF.
  // The index doubles as the character selector; the frame is nine characters
  // long and a request that arrives during a frame is ignored, save one while the line feed is shown, which starts a new frame.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      queryState_reg <= ssr_pkg::QRY_IDLE;
      queryIndex_reg <= 4'h0;
      queryValid_reg <= 1'b0;
      queryChar_reg  <= 8'h00;
    end else begin
      unique case (queryState_reg)
        ssr_pkg::QRY_IDLE: begin
          // Valid drops the cycle after the line feed was shown.
          queryValid_reg <= 1'b0;
          queryIndex_reg <= 4'h0;
          if (link.queryReq) begin
            queryState_reg <= ssr_pkg::QRY_SEND;
          end
        end
        ssr_pkg::QRY_SEND: begin
          queryValid_reg <= 1'b1;
          unique case (queryIndex_reg)
            4'h0: queryChar_reg <= hexChar(reportEnableMask_reg[7:4]);
            4'h1: queryChar_reg <= hexChar(reportEnableMask_reg[3:0]);
            4'h2: queryChar_reg <= ssr_pkg::CHAR_COMMA;
            4'h3: queryChar_reg <= hexChar(controlLimitBand_reg[15:12]);
            4'h4: queryChar_reg <= hexChar(controlLimitBand_reg[11:8]);
            4'h5: queryChar_reg <= hexChar(controlLimitBand_reg[7:4]);
            4'h6: queryChar_reg <= hexChar(controlLimitBand_reg[3:0]);
            4'h7: queryChar_reg <= ssr_pkg::CHAR_CR;
            default: queryChar_reg <= ssr_pkg::CHAR_LF;
          endcase
          if (queryIndex_reg == ssr_pkg::QUERY_LAST) begin
            queryState_reg <= ssr_pkg::QRY_IDLE;
          end
          // The index is reset to zero in idle, so it never needs to wrap.
          queryIndex_reg <= queryIndex_reg + 4'h1;
        end
        // Illegal state codes fall back to idle with the answer withdrawn.
        default: begin
          queryState_reg <= ssr_pkg::QRY_IDLE;
          queryValid_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link outputs: open-drain request drives low only when pulling.
  // The wire is never driven high, so other devices may share it.
  assign link.srqOut     = 1'b0;
  assign link.srqOe      = srqPull_reg;
  assign link.pollAck    = pollAck_reg;
  assign link.pollByte   = pollByte_reg;
  assign link.queryValid = queryValid_reg;
  assign link.queryChar  = queryChar_reg;
  // The save store keeps these across power cycles while the switch is on.
  assign maskOut         = reportEnableMask_reg;
  assign limitOut        = controlLimitBand_reg;

endmodule : ssr_instrument

// file: hdl/ssr_pkg.sv
// Shared constants and types for the status and service-request block.
package ssr_pkg;

  // Condition report bit positions.
  localparam int SAMPLE_BIT   = 0;
  localparam int CONTROL_BIT  = 1;
  localparam int LIMIT_BIT    = 2;
  localparam int CHANNEL_BIT  = 3;
  localparam int SUMMARY_BIT  = 4;
  localparam int OVERLOAD_BIT = 5;
  localparam int MASTER_BIT   = 6;

  // Upper mask digit weights.
  localparam logic [3:0] UPPER_OVERLOAD_WEIGHT = 4'h2;
  localparam logic [3:0] UPPER_MASTER_WEIGHT   = 4'h4;

  // Reset and power-up defaults.
  localparam logic [7:0]  MASK_DEFAULT  = 8'h00;
  localparam logic [15:0] LIMIT_DEFAULT = 16'h0000;
  localparam logic [7:0]  REPORT_RESET  = 8'h00;

  // Characters of the mask query answer.
  localparam logic [7:0] CHAR_COMMA = 8'h2c;
  localparam logic [7:0] CHAR_CR    = 8'h0d;
  localparam logic [7:0] CHAR_LF    = 8'h0a;
  localparam logic [7:0] CHAR_ZERO  = 8'h30;
  localparam logic [7:0] CHAR_DOT   = 8'h2e;
  localparam logic [7:0] CHAR_A     = 8'h41;
  localparam logic [3:0] QUERY_LAST = 4'h8;

  // Controller register map, byte addresses.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_QUERY  = 8'h0c;

  // Control register bits.
  localparam int CTRL_POLL  = 0;
  localparam int CTRL_SET   = 1;
  localparam int CTRL_QUERY = 2;

  // Mask query sender states.
  typedef enum logic [1:0] {
    QRY_IDLE = 2'b00,
    QRY_SEND = 2'b01
  } ssr_query_type;

endpackage : ssr_pkg

// file: hdl/ssr_link_if.sv
// Link between the instrument end and the bus controller end.
`timescale 1ns/1ps
interface ssr_link_if;
  logic        srqOut;
  logic        srqOe;
  logic        pollReq;
  logic        pollAck;
  logic [7:0]  pollByte;
  logic        maskSet;
  logic [7:0]  maskValue;
  logic [15:0] limitValue;
  logic        limitGiven;
  logic        queryReq;
  logic        queryValid;
  logic [7:0]  queryChar;
  // Open-drain service-request wire, low while any driver pulls.
  wire srqLine = ~(srqOe & ~srqOut);

  modport instrument (output srqOut, output srqOe, input pollReq, output pollAck,
                      output pollByte, input maskSet, input maskValue, input limitValue,
                      input limitGiven, input queryReq, output queryValid, output queryChar);
  modport controller (input srqLine, output pollReq, input pollAck, input pollByte,
                      output maskSet, output maskValue, output limitValue,
                      output limitGiven, output queryReq, input queryValid,
                      input queryChar);
endinterface : ssr_link_if

// file: hdl/ssr_controller.sv
// Bus controller end: APB registers, serial poll, mask set and mask query.
`timescale 1ns/1ps
module ssr_controller (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to the instrument
  ssr_link_if.controller   link
);

  logic        pollReq_reg;
  logic        maskSet_reg;
  logic        queryReq_reg;
  logic [7:0]  maskValue_reg;
  logic [15:0] limitValue_reg;
  logic        limitGiven_reg;
  logic [7:0]  pollResult_reg;
  logic [31:0] queryShift_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        access;
  logic        mapped;

  assign access = psel & penable;
  assign mapped = (paddr == ssr_pkg::REG_CTRL) | (paddr == ssr_pkg::REG_MASK)
                | (paddr == ssr_pkg::REG_STATUS) | (paddr == ssr_pkg::REG_QUERY);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; command bits are one-cycle pulses.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pollReq_reg    <= 1'b0;
      maskSet_reg    <= 1'b0;
      queryReq_reg   <= 1'b0;
      maskValue_reg  <= ssr_pkg::MASK_DEFAULT;
      limitValue_reg <= ssr_pkg::LIMIT_DEFAULT;
      limitGiven_reg <= 1'b0;
    end else begin
      pollReq_reg  <= 1'b0;
      maskSet_reg  <= 1'b0;
      queryReq_reg <= 1'b0;
      if (access && pwrite && paddr == ssr_pkg::REG_CTRL) begin
        pollReq_reg  <= pwdata[ssr_pkg::CTRL_POLL];
        maskSet_reg  <= pwdata[ssr_pkg::CTRL_SET];
        queryReq_reg <= pwdata[ssr_pkg::CTRL_QUERY];
      end
      if (access && pwrite && paddr == ssr_pkg::REG_MASK) begin
        maskValue_reg  <= pwdata[7:0];
        limitValue_reg <= pwdata[23:8];
        limitGiven_reg <= pwdata[24];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Poll result and last four query characters.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pollResult_reg <= ssr_pkg::REPORT_RESET;
      queryShift_reg <= 32'h00000000;
    end else begin
      if (link.pollAck) begin
        pollResult_reg <= link.pollByte;
      end
      if (link.queryValid) begin
        queryShift_reg <= {queryShift_reg[23:0], link.queryChar};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and error: zero wait states; unmapped gives pslverr.
  // The error flag is set in the setup cycle, so it stands for the access phase alone.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= psel & ~penable & ~mapped;
      unique case (paddr)
        ssr_pkg::REG_MASK:   prdata_reg <= {7'h00, limitGiven_reg, limitValue_reg, maskValue_reg};
        ssr_pkg::REG_STATUS: prdata_reg <= {23'h000000, ~link.srqLine, pollResult_reg};
        ssr_pkg::REG_QUERY:  prdata_reg <= queryShift_reg;
        default:             prdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = 1'b1;
  assign pslverr      = pslverr_reg;
  assign link.pollReq    = pollReq_reg;
  assign link.maskSet    = maskSet_reg;
  assign link.maskValue  = maskValue_reg;
  assign link.limitValue = limitValue_reg;
  assign link.limitGiven = limitGiven_reg;
  assign link.queryReq   = queryReq_reg;

endmodule : ssr_controller

// file: tb/ssr_link_asserts.sv
// Checker of the link between the instrument end and the controller end.
`timescale 1ns/1ps
module ssr_link_asserts (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // Service request and poll
  input wire logic       srqOut,
  input wire logic       srqOe,
  input wire logic       pollReq,
  input wire logic       pollAck,
  input wire logic [7:0] pollByte,
  // Mask set and query
  input wire logic       maskSet,
  input wire logic [7:0] maskValue,
  input wire logic       queryReq,
  input wire logic       queryValid,
  input wire logic [7:0] queryChar
);
  logic [7:0] maskCopy_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Copy of the mask from set commands; power-up loads are invisible on the link.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      maskCopy_reg <= 8'h00;
    end else if (maskSet) begin
      maskCopy_reg <= maskValue;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Answer frame: nine characters back to back.
  sequence s_frame;
    ##1 queryValid [*8] ##1 !queryValid;
  endsequence

  // Expected answer character for one mask digit, upper-case hex.
  function automatic logic [7:0] hexOf(input logic [3:0] nib);
    hexOf = (nib < 4'ha) ? 8'h30 + {4'h0, nib} : 8'h37 + {4'h0, nib};
  endfunction : hexOf

  // Mask characters: upper digit first, then lower digit.
  sequence s_mask_chars;
    queryChar == hexOf(maskCopy_reg[7:4]) ##1 queryChar == hexOf(maskCopy_reg[3:0]);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_poll_ack_next: assert property (pollReq |=> pollAck)
    else $error("poll not answered next cycle");
  a_ack_has_cause: assert property (pollAck |-> $past(pollReq))
    else $error("poll answer without request");
  a_srq_master_gate: assert property (srqOe |-> $past(maskCopy_reg[6]))
    else $error("request pulled with master gate off");
  a_srq_pull_low: assert property (srqOe |-> !srqOut && $past(maskCopy_reg[5:0]) != 6'h00)
    else $error("request pulled high or with no report enabled");
  a_poll_srq_flag: assert property (pollAck |-> pollByte[6] == $past(srqOe) && !pollByte[7])
    else $error("poll byte request flag wrong");
  a_query_mask: assert property ($rose(queryValid) |-> s_mask_chars)
    else $error("answer mask characters wrong");
  a_query_starts: assert property (queryReq && !queryValid |-> ##[1:3] $rose(queryValid))
    else $error("query answer did not start");
  a_query_length: assert property ($rose(queryValid) |-> s_frame)
    else $error("query answer length wrong");
  a_query_comma: assert property ($rose(queryValid) |-> ##2 queryChar == 8'h2c)
    else $error("third answer character not a comma");
  a_query_term: assert property ($fell(queryValid) |->
    $past(queryChar) == 8'h0a && $past(queryChar, 2) == 8'h0d)
    else $error("answer terminators wrong");
endmodule : ssr_link_asserts

// file: tb/status_service_request_bench.sv
// Bench joining both ends over the link and driving the controller over APB.
`timescale 1ns/1ps
module status_service_request_bench;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, savedMask, maskOut;
  logic [31:0] pwdata, prdata, rd;
  logic        sampleReady, controlReady, inLimitBand, channelChange, overload;
  logic        eventSummary, restoreSwitch, powerUpLoad;
  logic [15:0] savedLimit, limitOut;
  int          bad_count, check_count;

  ////////////////////////////////////////////////////////////////////////////////
  ssr_link_if ssr_link_if_inst ();
  ssr_instrument ssr_instrument_inst (.mclk(mclk), .reset_n(reset_n), .link(ssr_link_if_inst),
    .sampleReady(sampleReady), .controlReady(controlReady), .inLimitBand(inLimitBand),
    .channelChange(channelChange), .overload(overload), .eventSummary(eventSummary),
    .restoreSwitch(restoreSwitch), .powerUpLoad(powerUpLoad), .savedMask(savedMask),
    .savedLimit(savedLimit), .maskOut(maskOut), .limitOut(limitOut));
  ssr_controller ssr_controller_inst (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(ssr_link_if_inst));
  ssr_link_asserts ssr_link_asserts_inst (.mclk(mclk), .reset_n(reset_n),
    .srqOut(ssr_link_if_inst.srqOut), .srqOe(ssr_link_if_inst.srqOe),
    .pollReq(ssr_link_if_inst.pollReq), .pollAck(ssr_link_if_inst.pollAck),
    .pollByte(ssr_link_if_inst.pollByte),
    .maskSet(ssr_link_if_inst.maskSet), .maskValue(ssr_link_if_inst.maskValue),
    .queryReq(ssr_link_if_inst.queryReq), .queryValid(ssr_link_if_inst.queryValid),
    .queryChar(ssr_link_if_inst.queryChar));

  ////////////////////////////////////////////////////////////////////////////////
  task summarize();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    // Only the watchdog ends a wait that never sees pready.
    while (pready !== 1'h1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask : apb

  // Serial poll, then the polled byte is read back from the status register.
  task poll(input logic [7:0] exp);
    apb(1'h1, ssr_pkg::REG_CTRL, 32'h1);
    repeat (3) @(posedge mclk);
    apb(1'h0, ssr_pkg::REG_STATUS, 32'h0);
    chk({24'h0, rd[7:0]}, {24'h0, exp});
  endtask : poll

  task setMask(input logic [7:0] m, input logic [15:0] lim, input logic given);
    apb(1'h1, ssr_pkg::REG_MASK, {7'h0, given, lim, m});
    apb(1'h1, ssr_pkg::REG_CTRL, 32'h2);
    repeat (4) @(posedge mclk);
  endtask : setMask

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 40 MHz clock.
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // Watchdog well beyond the roughly 180 cycles the tests need.
  initial begin
    #100000;
    bad_count++;
    summarize();
  end

  // Main sequence.
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {sampleReady, controlReady, inLimitBand, channelChange, overload} = '0;
    {eventSummary, restoreSwitch, powerUpLoad, savedMask, savedLimit} = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
    chk({24'h0, maskOut}, 32'h0);
    setMask(8'h61, 16'h1234, 1'h0);
    chk({24'h0, maskOut}, 32'h61);
    chk({16'h0, limitOut}, 32'h0);
    apb(1'h0, ssr_pkg::REG_MASK, 32'h0);
    chk(rd, 32'h00123461);
    chk({31'h0, err}, 32'h0);
    sampleReady <= 1'h1;
    repeat (4) @(posedge mclk);
    chk({31'h0, ssr_link_if_inst.srqLine}, 32'h0);
    poll(8'h41);
    chk({31'h0, rd[8]}, 32'h1);
    setMask(8'h21, 16'h0000, 1'h0);
    chk({31'h0, ssr_link_if_inst.srqLine}, 32'h1);
    poll(8'h01);
    setMask(8'h44, 16'h0001, 1'h1);
    controlReady <= 1'h1;
    inLimitBand <= 1'h1;
    repeat (3) @(posedge mclk);
    poll(8'h47);
    poll(8'h47);
    inLimitBand <= 1'h0;
    controlReady <= 1'h0;
    poll(8'h45);
    poll(8'h01);
    chk({31'h0, ssr_link_if_inst.srqLine}, 32'h1);
    setMask(8'h68, 16'h0000, 1'h0);
    channelChange <= 1'h1;
    @(posedge mclk);
    channelChange <= 1'h0;
    repeat (2) @(posedge mclk);
    poll(8'h49);
    overload <= 1'h1;
    eventSummary <= 1'h1;
    repeat (3) @(posedge mclk);
    poll(8'h71);
    poll(8'h71);
    setMask(8'h06, 16'h0001, 1'h1);
    chk({16'h0, limitOut}, 32'h1);
    apb(1'h1, ssr_pkg::REG_CTRL, 32'h4);
    repeat (14) @(posedge mclk);
    apb(1'h0, ssr_pkg::REG_QUERY, 32'h0);
    chk(rd, 32'h30310d0a);
    apb(1'h0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    restoreSwitch <= 1'h1;
    savedMask <= 8'h2f;
    savedLimit <= 16'h0123;
    powerUpLoad <= 1'h1;
    @(posedge mclk);
    powerUpLoad <= 1'h0;
    repeat (2) @(posedge mclk);
    chk({8'h0, limitOut, maskOut}, 32'h01232f);
    restoreSwitch <= 1'h0;
    powerUpLoad <= 1'h1;
    @(posedge mclk);
    powerUpLoad <= 1'h0;
    repeat (2) @(posedge mclk);
    chk({8'h0, limitOut, maskOut}, 32'h0);
    summarize();
  end
endmodule : status_service_request_bench
